// ### hdl/watchdog_timeout_unit.v
// Watchdog timeout unit with its special function register slice
//
// Functional notes
// - Counter runs until the reset flag sets; interrupt flag sets when selected period is reached.
// - Restart command returns the count to zero.
// - Period select is bits 7 (upper) and 6 (lower) of clock speed control.
// - Interrupt period is 2^17, 2^20, 2^23 or 2^26 clocks by code.
// - Reset flag sets 512 clocks after the interrupt flag.
// - Interrupt forwarding depends only on its own enable bit.
// - With reset enabled, an unrestarted timeout resets the CPU.
// - Reset-enable and restart writes need the protected-write unlock.
// - Enabled interrupt request serves as time base and idle wake-up.
// - Counter advances once per oscillator clock.
`timescale 1ns/1ps
`default_nettype none
`include "wdt_defines.vh"
module watchdog_timeout_unit #(
    parameter integer WIDTH = `COUNT_WIDTH,
    parameter integer LOG2_0 = `PERIOD_LOG2_0,
    parameter integer LOG2_1 = `PERIOD_LOG2_1,
    parameter integer LOG2_2 = `PERIOD_LOG2_2,
    parameter integer LOG2_3 = `PERIOD_LOG2_3,
    parameter integer LEAD = `RESET_LEAD_CLOCKS
) (
    input wire clock_in, // Oscillator clock
    input wire rst_b_in, // System reset, active low
    input wire [7:0] sfr_addr_in, // Register address
    input wire sfr_wr_in, // Write strobe
    input wire sfr_rd_in, // Read strobe
    input wire [7:0] sfr_wdata_in, // Write data
    input wire unlock_grant_in, // Protected-write grant, one cycle
    output reg [7:0] sfr_rdata_out, // Read data, registered
    output reg irq_req_out, // Watchdog interrupt request
    output reg wake_out, // Idle wake-up request
    output reg cpu_reset_out // CPU reset request
);
    // Register slice state
    reg [7:0] clock_speed_control_q;
    reg [7:0] clock_speed_control_d;
    reg [7:0] eie_q;
    reg [7:0] eie_d;
    reg rst_en_q;
    reg rst_en_d;
    reg irq_flag_q;
    reg irq_flag_d;
    reg rst_flag_q;
    reg rst_flag_d;
    reg [WIDTH-1:0] count_q;
    reg [WIDTH-1:0] count_d;
    // Next values of the registered outputs
    reg [7:0] rdata_d;
    reg irq_req_d;
    reg wake_d;
    reg cpu_reset_d;
    // Terminal counts from the period decoder
    wire [WIDTH-1:0] irq_count;
    wire [WIDTH-1:0] rst_count;
    wire [WIDTH-1:0] irq_last;
    wire [WIDTH-1:0] rst_last;
    wire [WIDTH-1:0] count_one;
    wire [7:0] watchdog_control_view;
    // Address decode of the three mapped registers
    wire sel_ck;
    wire sel_wd;
    wire sel_ie;
    wire wr_ck;
    wire wr_wd;
    wire wr_ie;
    wire guarded_ok;
    wire restart;
    wire clear_irq;
    wire clear_rst;
    wire hit_irq;
    wire hit_rst;
    wire irq_en;

    assign sel_ck = (sfr_addr_in == `ADDR_CLOCK_SPEED_CONTROL);
    assign sel_wd = (sfr_addr_in == `ADDR_WATCHDOG_CONTROL);
    assign sel_ie = (sfr_addr_in == `ADDR_EXTENDED_IRQ_ENABLE);
    assign wr_ck = sfr_wr_in && sel_ck;
    assign wr_wd = sfr_wr_in && sel_wd;
    assign wr_ie = sfr_wr_in && sel_ie;

    // Only the grant qualifies guarded bits; flag clears stay unguarded
    assign guarded_ok = wr_wd && unlock_grant_in;
    assign restart = guarded_ok && sfr_wdata_in[`WDC_RESTART_BIT];
    assign clear_irq = wr_wd && !sfr_wdata_in[`WDC_IRQ_FLAG_BIT];
    assign clear_rst = wr_wd && !sfr_wdata_in[`WDC_RESET_FLAG_BIT];
    assign irq_en = eie_q[`EIE_WDOG_IRQ_EN_BIT];

    // Compare one below the terminal count so the flag lands on the terminal edge
    assign count_one = {{(WIDTH-1){1'b0}}, 1'b1};
    assign irq_last = irq_count - count_one;
    assign rst_last = rst_count - count_one;
    assign hit_irq = (count_q == irq_last);
    assign hit_rst = (count_q == rst_last);

    wdt_period_decode #(
        .WIDTH(WIDTH),
        .LOG2_0(LOG2_0),
        .LOG2_1(LOG2_1),
        .LOG2_2(LOG2_2),
        .LOG2_3(LOG2_3),
        .LEAD(LEAD)
    ) u_decode (
        .select_in({clock_speed_control_q[`PERIOD_SELECT_HI_BIT], clock_speed_control_q[`PERIOD_SELECT_LO_BIT]}),
        .irq_count_out(irq_count),
        .rst_count_out(rst_count)
    );

    // Restart reads back as zero; upper bits are unused
    assign watchdog_control_view = {4'h0, irq_flag_q, rst_flag_q, rst_en_q, 1'b0};

    always @* begin
        clock_speed_control_d = clock_speed_control_q;
        eie_d = eie_q;
        rst_en_d = rst_en_q;
        if (wr_ck) begin
            clock_speed_control_d = sfr_wdata_in;
        end
        if (wr_ie) begin
            eie_d = sfr_wdata_in;
        end
        // Without the grant the stored enable is left untouched
        if (guarded_ok) begin
            rst_en_d = sfr_wdata_in[`WDC_RESET_EN_BIT];
        end
    end

    // Counter freezes once the reset flag is up so it cannot wrap and retrigger
    always @* begin
        count_d = count_q;
        if (restart) begin
            count_d = {WIDTH{1'b0}};
        end else if (!rst_flag_q) begin
            count_d = count_q + count_one;
        end
    end

    // Hardware set wins over a software clear in the same cycle, except on a restart write, which suppresses the set
    always @* begin
        irq_flag_d = irq_flag_q;
        rst_flag_d = rst_flag_q;
        if (hit_irq && !restart) begin
            irq_flag_d = 1'b1;
        end else if (clear_irq) begin
            irq_flag_d = 1'b0;
        end
        if (hit_rst && !restart) begin
            rst_flag_d = 1'b1;
        end else if (restart || clear_rst) begin
            rst_flag_d = 1'b0;
        end
    end

    // Read data only changes on a read strobe, so it holds between reads
    always @* begin
        rdata_d = sfr_rdata_out;
        if (sfr_rd_in) begin
            case (sfr_addr_in)
                `ADDR_CLOCK_SPEED_CONTROL: begin
                    rdata_d = clock_speed_control_q;
                end
                `ADDR_WATCHDOG_CONTROL: begin
                    rdata_d = watchdog_control_view;
                end
                `ADDR_EXTENDED_IRQ_ENABLE: begin
                    rdata_d = eie_q;
                end
                default: begin
                    rdata_d = 8'h00;
                end
            endcase
        end
    end

    always @* begin
        irq_req_d = irq_flag_q && irq_en;
        wake_d = irq_flag_q && irq_en;
        cpu_reset_d = rst_flag_q && rst_en_q;
    end

    always @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            clock_speed_control_q <= `CLOCK_SPEED_CONTROL_RESET;
            eie_q <= `EIE_RESET;
            rst_en_q <= 1'b0;
        end else begin
            clock_speed_control_q <= clock_speed_control_d;
            eie_q <= eie_d;
            rst_en_q <= rst_en_d;
        end
    end

    always @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            count_q <= {WIDTH{1'b0}};
        end else begin
            count_q <= count_d;
        end
    end

    always @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            irq_flag_q <= 1'b0;
            rst_flag_q <= 1'b0;
        end else begin
            irq_flag_q <= irq_flag_d;
            rst_flag_q <= rst_flag_d;
        end
    end

    // Every top output leaves straight from a flip-flop
    always @(posedge clock_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            sfr_rdata_out <= 8'h00;
            irq_req_out <= 1'b0;
            wake_out <= 1'b0;
            cpu_reset_out <= 1'b0;
        end else begin
            sfr_rdata_out <= rdata_d;
            irq_req_out <= irq_req_d;
            wake_out <= wake_d;
            cpu_reset_out <= cpu_reset_d;
        end
    end
endmodule
`default_nettype wire

// ### hdl/wdt_defines.vh
// Constants for the watchdog timeout unit
`ifndef WDT_DEFINES_VH
`define WDT_DEFINES_VH
`define ADDR_CLOCK_SPEED_CONTROL 8'h8E
`define ADDR_WATCHDOG_CONTROL 8'hD8
`define ADDR_EXTENDED_IRQ_ENABLE 8'hE8
`define PERIOD_SELECT_HI_BIT 7
`define PERIOD_SELECT_LO_BIT 6
`define WDC_IRQ_FLAG_BIT 3
`define WDC_RESET_FLAG_BIT 2
`define WDC_RESET_EN_BIT 1
`define WDC_RESTART_BIT 0
`define EIE_WDOG_IRQ_EN_BIT 6
`define CLOCK_SPEED_CONTROL_RESET 8'h00
`define WATCHDOG_CONTROL_RESET 8'h00
`define EIE_RESET 8'h00
`define PERIOD_LOG2_0 17
`define PERIOD_LOG2_1 20
`define PERIOD_LOG2_2 23
`define PERIOD_LOG2_3 26
`define RESET_LEAD_CLOCKS 512
`define COUNT_WIDTH 27
`endif

// ### hdl/wdt_period_decode.v
// Period select decode into interrupt and reset terminal counts
`timescale 1ns/1ps
`default_nettype none
`include "wdt_defines.vh"
module wdt_period_decode #(
    parameter integer WIDTH = `COUNT_WIDTH,
    parameter integer LOG2_0 = `PERIOD_LOG2_0,
    parameter integer LOG2_1 = `PERIOD_LOG2_1,
    parameter integer LOG2_2 = `PERIOD_LOG2_2,
    parameter integer LOG2_3 = `PERIOD_LOG2_3,
    parameter integer LEAD = `RESET_LEAD_CLOCKS
) (
    input wire [1:0] select_in, // Period select code
    output reg [WIDTH-1:0] irq_count_out, // Clocks to interrupt flag
    output reg [WIDTH-1:0] rst_count_out // Clocks to reset flag
);
    localparam [WIDTH-1:0] ONE = {{(WIDTH-1){1'b0}}, 1'b1};
    localparam [WIDTH-1:0] LEAD_W = LEAD[WIDTH-1:0];
    always @* begin
        case (select_in)
            2'b00: irq_count_out = ONE << LOG2_0;
            2'b01: irq_count_out = ONE << LOG2_1;
            2'b10: irq_count_out = ONE << LOG2_2;
            default: irq_count_out = ONE << LOG2_3;
        endcase
        rst_count_out = irq_count_out + LEAD_W;
    end
endmodule
`default_nettype wire

// ### testbench/watchdog_timeout_unit_monitor.sv
// Assertion checker for the watchdog timeout unit
`timescale 1ns/1ps
`default_nettype none
module watchdog_timeout_unit_monitor (
    input wire logic clock_in, rst_b_in, sfr_wr_in, sfr_rd_in, unlock_grant_in, // Control
    input wire logic [7:0] sfr_addr_in, sfr_wdata_in, sfr_rdata_out, // Bus
    input wire logic irq_req_out, wake_out, cpu_reset_out // Outputs
);
    wire rs = sfr_wr_in && sfr_addr_in == 8'hD8 && unlock_grant_in && sfr_wdata_in[0];
    wire ck_wr = sfr_wr_in && sfr_addr_in == 8'h8E;
    wire ck_rd = sfr_rd_in && !sfr_wr_in && sfr_addr_in == 8'h8E;
    wire unmap = !(sfr_addr_in inside {8'h8E, 8'hD8, 8'hE8});
    default clocking @(posedge clock_in); endclocking
    default disable iff (!rst_b_in);
    AST_WAKE: assert property (wake_out == irq_req_out) else $error("wake");
    AST_RS_IRQ: assert property (rs && !sfr_wdata_in[3] |-> ##2 !irq_req_out [*8])
        else $error("early irq");
    AST_RS_RST: assert property (rs |-> ##2 !cpu_reset_out [*8])
        else $error("early reset");
    AST_CK_RW: assert property (ck_wr ##1 ck_rd |=> sfr_rdata_out == $past(sfr_wdata_in, 2))
        else $error("readback");
    AST_UNMAP: assert property (sfr_rd_in && unmap |=> sfr_rdata_out == 8'h00)
        else $error("unmapped read");
    AST_HOLD: assert property (!sfr_rd_in |=> $stable(sfr_rdata_out)) else $error("rdata");
    AST_IRQ_KEEP: assert property (irq_req_out && !sfr_wr_in && !$past(sfr_wr_in) |=> irq_req_out)
        else $error("irq drop");
    AST_RST_KEEP: assert property (cpu_reset_out && !sfr_wr_in && !$past(sfr_wr_in) |=> cpu_reset_out)
        else $error("reset drop");
    C_IRQ: cover property ($rose(irq_req_out));
    C_RST: cover property ($rose(cpu_reset_out));
    C_RS: cover property (rs);
endmodule
bind watchdog_timeout_unit watchdog_timeout_unit_monitor u_mon (.clock_in, .rst_b_in,
    .sfr_addr_in, .sfr_wr_in, .sfr_rd_in, .sfr_wdata_in, .unlock_grant_in, .sfr_rdata_out,
    .irq_req_out, .wake_out, .cpu_reset_out);
`default_nettype wire

// ### testbench/watchdog_timeout_unit_test.sv
// Self-checking bench for the watchdog timeout unit
`timescale 1ns/1ps
`default_nettype none
module watchdog_timeout_unit_test;
    localparam int lg [4] = '{4, 5, 6, 7};
    logic clock_in = 1'b0, rst_b_in = 1'b0, wr = 1'b0, rd = 1'b0, gr = 1'b0;
    logic [7:0] addr = 8'h00, wd = 8'h00, rdata;
    logic irq, wake, crst;
    int error_cnt = 0, total_checks = 0, cyc = 0, n, m;
    always #10 clock_in = ~clock_in;
    // Short periods keep the run brief
    watchdog_timeout_unit #(.LOG2_0(lg[0]), .LOG2_1(lg[1]), .LOG2_2(lg[2]), .LOG2_3(lg[3]),
        .LEAD(8)) u_dut (.clock_in, .rst_b_in, .sfr_addr_in(addr), .sfr_wr_in(wr),
        .sfr_rd_in(rd), .sfr_wdata_in(wd), .unlock_grant_in(gr), .sfr_rdata_out(rdata),
        .irq_req_out(irq), .wake_out(wake), .cpu_reset_out(crst));
    task idle;
        wr = 1'b0;
        rd = 1'b0;
        @(posedge clock_in) #1;
    endtask
    task op(input logic [7:0] a, d, input logic g);
        wr = 1'b1; rd = 1'b0; addr = a; wd = d; gr = g;
        @(posedge clock_in) #1;
    endtask
    task ck(input logic [7:0] g, e);
        total_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD %0t got %h exp %h", $time, g, e);
        end
    endtask
    task rdc(input logic [7:0] a, e);
        wr = 1'b0; rd = 1'b1; addr = a;
        @(posedge clock_in) #1;
        ck(rdata, e);
    endtask
    task t_regs;
        rdc(8'h8E, 8'h00);
        op(8'h8E, 8'hC5, 1'b0);
        rdc(8'h8E, 8'hC5);
        rdc(8'h55, 8'h00);
    endtask
    task t_period;
        for (int c = 0; c < 4; c++) begin
            op(8'h8E, 8'(c << 6), 1'b0);
            op(8'hE8, 8'h40, 1'b0);
            op(8'hD8, 8'h03, 1'b1);
            repeat (10) idle;
            op(8'hD8, 8'h03, 1'b1);
            for (n = 0; !irq && n < 300; n++) idle;
            ck(8'(n), 8'((1 << lg[c]) + 1));
            for (m = 0; !crst && m < 300; m++) idle;
            ck(8'(m), 8'h08);
            repeat (3) idle;
        end
    endtask
    task t_mask;
        op(8'hE8, 8'h00, 1'b0);
        op(8'h8E, 8'h00, 1'b0);
        op(8'hD8, 8'h01, 1'b1);
        repeat (30) idle;
        ck({irq, crst}, 8'h00);
        rdc(8'hD8, 8'h0C);
        op(8'hE8, 8'h40, 1'b0);
        idle;
        ck({wake, irq}, 8'h03);
        op(8'hD8, 8'h0F, 1'b0);
        rdc(8'hD8, 8'h0C);
        op(8'hD8, 8'h0E, 1'b1);
        idle;
        ck(crst, 8'h01);
        op(8'hD8, 8'h0A, 1'b0);
        rdc(8'hD8, 8'h0A);
    endtask
    task finish_test;
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clock_in);
        #1 rst_b_in = 1'b1;
        t_regs;
        t_period;
        t_mask;
        finish_test;
    end
    always @(posedge clock_in) begin
        cyc++;
        if (cyc == 3000) begin
            error_cnt++;
            finish_test;
        end
    end
endmodule
`default_nettype wire
